// [src/stc_pkg.sv]
/*
  Constants, timing figures and types shared by the source transfer controller.
  Assumes a 20 MHz system clock; all delays run on a 100 ms tick.
*/
// Function
// - One-shot modes change over once to backup and never return.
// - Semi mode transfers after delay; without generator, returns only if new channel loses voltage.
// - Auto modes return to priority channel on restored voltage; input selects priority.
// - Network pair: open normal channel after transfer delay, then close backup.
// - Generator pair: open network and start generator in the same cycle.
// - Close-after-start: close generator channel without waiting for generator voltage.
// - Close-after-power-on: hold generator close until generator voltage is seen.
// - Transfer delay spans zero to two minutes in 100 ms steps.
// - Return delay spans zero to thirty minutes in 5 s steps.
// - No paralleling: open backup, confirm open, then close priority.
// - Paralleling: close priority, confirm closed, then open backup.
// - Paralleling acts only while the confirmation input is active.
// - Changeover needs automation on, one switch closed, no locks, no earthing, voltages.
// - Return needs priority switch open and voltage steady for the return delay.
// - Generator override forces automation on; its end restores the previous state.
// - Transfer lock blocks changeover and refuses manual switch commands.
// - Generator start failure abandons within 60 s; one-shot generator mode locks.
// - After generator transfer, network voltage return requests a return.
// - With auto return, generator stop follows 6 s after the return completes.
// - Generator voltage comes from the dedicated input or the detection relay.
// - Automation serves channels 1 and 2; generator variant only on first module.
// - Manual operation accepted with automation off or switch in local mode.
package stc_pkg;
  localparam int CLOCK_HZ = 20_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
  localparam int T1_MAX_MIN = 2;
  localparam int T1_MAX_TICKS = T1_MAX_MIN * 60 * 1000 / TICK_MS;
  localparam int T2_STEP_S = 5;
  localparam int T2_MAX_MIN = 30;
  localparam int T2_MAX_STEPS = T2_MAX_MIN * 60 / T2_STEP_S;
  localparam logic [15:0] T2_STEP_TICKS = 16'(T2_STEP_S * 1000 / TICK_MS);
  localparam int GEN_TIMEOUT_S = 60;
  localparam logic [15:0] GEN_TIMEOUT_TICKS = 16'(GEN_TIMEOUT_S * 1000 / TICK_MS);
  localparam int STOP_DELAY_S = 6;
  localparam logic [15:0] STOP_DELAY_TICKS = 16'(STOP_DELAY_S * 1000 / TICK_MS);
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [1:0] ORDERS_RESET = 2'h0;

  typedef enum logic [2:0] {
    MODE_ONE_1TO2, MODE_ONE_2TO1, MODE_SEMI, MODE_AUTO1, MODE_AUTO2
  } stc_mode_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_T1_WAIT, ST_XFER_OPEN, ST_XFER_CLOSE, ST_RET_WAIT,
    ST_RET_OPEN_FIRST, ST_RET_CLOSE_LAST, ST_RET_CLOSE_FIRST, ST_RET_OPEN_LAST,
    ST_STOP_WAIT, ST_LOCKED
  } stc_state_type;
endpackage : stc_pkg

// [src/stc_source_transfer_controller.sv]
/*
  Source transfer controller: changeover between two feeder channels or a
  network and a generator channel. Pin inputs come from the switchgear and are
  synchronised here; configuration ports come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module stc_source_transfer_controller #(
  parameter int TICK_CYCLES = stc_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [1:0] sw_closed,
  input wire logic [1:0] earth_closed,
  input wire logic [1:0] volt_present,
  input wire logic [1:0] fault_current,
  input wire logic gen_volt_input,
  input wire logic transfer_lock,
  input wire logic priority_select,
  input wire logic parallel_confirm,
  input wire logic gen_override,
  input wire logic local_mode,
  input wire logic [1:0] manual_open,
  input wire logic [1:0] manual_close,
  input wire logic auto_on,
  input wire stc_pkg::stc_mode_type mode,
  input wire logic gen_variant,
  input wire logic first_module,
  input wire logic gen_channel,
  input wire logic volt_from_relay,
  input wire logic fault_lock_en,
  input wire logic parallel_en,
  input wire logic close_after_start,
  input wire logic [10:0] transfer_delay,
  input wire logic [8:0] return_delay,
  input wire logic panel_reset,
  output logic [1:0] open_order,
  output logic [1:0] close_order,
  output logic gen_start,
  output logic gen_stop,
  output logic locked,
  output logic automation_active
);
  // The tick divider is 24 bits wide and must count at least two cycles.
  if (TICK_CYCLES < 2 || TICK_CYCLES > 16_777_215) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  localparam int NPIN = 18;
  logic [NPIN-1:0] pin_a;
  logic [NPIN-1:0] pin_b;
  logic [23:0] tick_cnt;
  logic tick;
  stc_pkg::stc_state_type state, next_state;
  logic [15:0] timer, next_timer;
  logic src, next_src, dst, next_dst;
  logic oneshot_done, next_oneshot_done;
  logic next_gen_start, next_gen_stop, next_locked;
  logic [1:0] next_open_order, next_close_order;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_a <= '0;
      pin_b <= '0;
    end else begin
      pin_a <= {sw_closed, earth_closed, volt_present, fault_current, gen_volt_input,
                transfer_lock, priority_select, parallel_confirm, gen_override, local_mode,
                manual_open, manual_close};
      pin_b <= pin_a;
    end
  end

  logic [1:0] sw, earth, volt, fault, m_open, m_close;
  logic gen_v_in, lock_in, prio_in, par_in, ovr_in, local_in;
  assign {sw, earth, volt, fault, gen_v_in, lock_in, prio_in, par_in, ovr_in, local_in,
          m_open, m_close} = pin_b;

  // The tick is shared by every delay so one divider serves them all.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 24'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 24'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 24'h000001;
    end
  end

  logic gen_eff, auto_eff, auto_mode, oneshot_mode, one_swc, par_eff;
  logic [1:0] v;
  logic active, other, prio, start_ok, ret_ok, dst_gen;
  logic [15:0] t2_ticks;
  assign gen_eff = gen_variant && first_module;
  assign auto_eff = (gen_eff && ovr_in) || auto_on;
  assign automation_active = auto_eff;
  assign auto_mode = (mode == stc_pkg::MODE_AUTO1) || (mode == stc_pkg::MODE_AUTO2);
  assign oneshot_mode = (mode == stc_pkg::MODE_ONE_1TO2) || (mode == stc_pkg::MODE_ONE_2TO1);
  assign par_eff = parallel_en && par_in;
  // Only the generator channel may take its voltage from the dedicated input.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      v[i] = (gen_eff && gen_channel == 1'(i) && !volt_from_relay) ? gen_v_in : volt[i];
    end
  end
  assign one_swc = sw[0] ^ sw[1];
  assign active = sw[1];
  assign other = !active;
  assign prio = gen_eff ? !gen_channel
              : ((mode == stc_pkg::MODE_AUTO2) || (mode == stc_pkg::MODE_ONE_2TO1))
                ^ (auto_mode && prio_in);
  assign dst_gen = gen_eff && (dst == gen_channel);
  assign t2_ticks = 16'(return_delay * stc_pkg::T2_STEP_TICKS);

  // A generator channel shows no voltage until the changeover itself starts the set.
  assign start_ok = auto_eff && one_swc && !lock_in && !(|earth) && !v[active]
                    && (v[other] || (gen_eff && other == gen_channel))
                    && !(fault_lock_en && |fault)
                    && !(oneshot_mode && (oneshot_done || active != prio));
  assign ret_ok = auto_eff && one_swc && !lock_in && !(|earth) && active != prio
                  && !sw[prio] && v[prio]
                  && (auto_mode || (gen_eff && !oneshot_mode));

  always_comb begin
    next_state = state;
    next_src = src;
    next_dst = dst;
    next_timer = tick ? timer + 16'h0001 : timer;
    next_oneshot_done = oneshot_done && !panel_reset;
    next_gen_start = gen_start;
    next_gen_stop = gen_stop;
    case (state)
      stc_pkg::ST_IDLE: begin
        next_timer = stc_pkg::TIMER_RESET;
        if (start_ok) begin
          next_state = stc_pkg::ST_T1_WAIT;
        end else if (ret_ok) begin
          next_state = stc_pkg::ST_RET_WAIT;
        end
      end
      stc_pkg::ST_T1_WAIT: begin
        if (!start_ok) begin
          next_state = stc_pkg::ST_IDLE;
        end else if (timer >= 16'(transfer_delay)) begin
          next_state = stc_pkg::ST_XFER_OPEN;
          next_src = active;
          next_dst = other;
          next_timer = stc_pkg::TIMER_RESET;
          if (gen_eff && other == gen_channel) begin
            next_gen_start = 1'b1;
            next_gen_stop = 1'b0;
          end
        end
      end
      stc_pkg::ST_XFER_OPEN: begin
        if (!sw[src]) begin
          next_state = stc_pkg::ST_XFER_CLOSE;
        end
      end
      stc_pkg::ST_XFER_CLOSE: begin
        if (sw[dst]) begin
          next_state = stc_pkg::ST_IDLE;
          next_oneshot_done = oneshot_mode;
        end else if (dst_gen && timer >= stc_pkg::GEN_TIMEOUT_TICKS) begin
          next_gen_start = 1'b0;
          next_state = oneshot_mode ? stc_pkg::ST_LOCKED : stc_pkg::ST_IDLE;
        end
      end
      stc_pkg::ST_RET_WAIT: begin
        if (!ret_ok) begin
          next_state = stc_pkg::ST_IDLE;
        end else if (timer >= t2_ticks) begin
          next_state = par_eff ? stc_pkg::ST_RET_CLOSE_FIRST : stc_pkg::ST_RET_OPEN_FIRST;
          next_src = active;
          next_dst = prio;
        end
      end
      stc_pkg::ST_RET_OPEN_FIRST: begin
        if (!sw[src]) begin
          next_state = stc_pkg::ST_RET_CLOSE_LAST;
        end
      end
      stc_pkg::ST_RET_CLOSE_FIRST: begin
        if (sw[dst]) begin
          next_state = stc_pkg::ST_RET_OPEN_LAST;
        end
      end
      stc_pkg::ST_RET_CLOSE_LAST, stc_pkg::ST_RET_OPEN_LAST: begin
        if ((state == stc_pkg::ST_RET_CLOSE_LAST) ? sw[dst] : !sw[src]) begin
          next_state = gen_start ? stc_pkg::ST_STOP_WAIT : stc_pkg::ST_IDLE;
          next_timer = stc_pkg::TIMER_RESET;
        end
      end
      stc_pkg::ST_STOP_WAIT: begin
        if (timer >= stc_pkg::STOP_DELAY_TICKS) begin
          next_gen_start = 1'b0;
          next_gen_stop = 1'b1;
          next_state = stc_pkg::ST_IDLE;
        end
      end
      stc_pkg::ST_LOCKED: begin
        next_timer = stc_pkg::TIMER_RESET;
        if (panel_reset) begin
          next_state = stc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = stc_pkg::ST_IDLE;
      end
    endcase
    // Entering lock sets the flag even in the cycle a panel reset arrives.
    next_locked = (next_state == stc_pkg::ST_LOCKED) || (locked && !panel_reset);
  end

  // Manual commands pass only from idle, so they never fight a running sequence.
  logic manual_ok;
  assign manual_ok = (!auto_eff || local_in) && !lock_in
                     && state == stc_pkg::ST_IDLE;

  always_comb begin
    next_open_order = manual_ok ? m_open : stc_pkg::ORDERS_RESET;
    next_close_order = manual_ok ? m_close : stc_pkg::ORDERS_RESET;
    case (next_state)
      stc_pkg::ST_XFER_OPEN, stc_pkg::ST_RET_OPEN_FIRST, stc_pkg::ST_RET_OPEN_LAST: begin
        next_open_order[next_src] = 1'b1;
      end
      stc_pkg::ST_XFER_CLOSE: begin
        if (!(gen_eff && next_dst == gen_channel) || close_after_start || v[next_dst]) begin
          next_close_order[next_dst] = 1'b1;
        end
      end
      stc_pkg::ST_RET_CLOSE_FIRST, stc_pkg::ST_RET_CLOSE_LAST: begin
        next_close_order[next_dst] = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= stc_pkg::ST_IDLE;
      timer <= stc_pkg::TIMER_RESET;
      src <= 1'b0;
      dst <= 1'b0;
      oneshot_done <= 1'b0;
      gen_start <= 1'b0;
      gen_stop <= 1'b0;
      locked <= 1'b0;
      open_order <= stc_pkg::ORDERS_RESET;
      close_order <= stc_pkg::ORDERS_RESET;
    end else begin
      state <= next_state;
      timer <= next_timer;
      src <= next_src;
      dst <= next_dst;
      oneshot_done <= next_oneshot_done;
      gen_start <= next_gen_start;
      gen_stop <= next_gen_stop;
      locked <= next_locked;
      open_order <= next_open_order;
      close_order <= next_close_order;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_xfer_entry;
    state == stc_pkg::ST_T1_WAIT && next_state == stc_pkg::ST_XFER_OPEN;
  endsequence
  sequence s_gen_dst;
    gen_eff && next_dst == gen_channel;
  endsequence

  chk_start_with_open: assert property (s_xfer_entry and s_gen_dst |=>
    gen_start && open_order[src]) else $error("start and open not together");
  chk_delay_respected: assert property (s_xfer_entry |->
    timer >= 16'(transfer_delay)) else $error("transfer before delay");
  chk_cond_in_wait: assert property (state == stc_pkg::ST_T1_WAIT && $stable(state)
    |-> $past(start_ok)) else $error("delay ran without conditions");
  chk_lock_blocks: assert property (lock_in |=> state != stc_pkg::ST_XFER_OPEN
    || $past(state) == stc_pkg::ST_XFER_OPEN) else $error("transfer under lock");
  chk_oneshot_noret: assert property (oneshot_mode && !gen_eff
    |-> state != stc_pkg::ST_RET_WAIT) else $error("one-shot returned");
  chk_close_waits_gen: assert property (state == stc_pkg::ST_XFER_CLOSE && dst_gen
    && !close_after_start && !v[dst] |=> !close_order[dst]) else $error("gen closed early");
  chk_nopar_order: assert property (state == stc_pkg::ST_RET_CLOSE_LAST
    |-> $past(state) == stc_pkg::ST_RET_OPEN_FIRST || $stable(state))
    else $error("priority closed before backup open");
  chk_gen_timeout: assert property (state == stc_pkg::ST_XFER_CLOSE && dst_gen
    |-> timer <= stc_pkg::GEN_TIMEOUT_TICKS) else $error("generator wait too long");
  chk_stop_delay: assert property ($rose(gen_stop) |->
    $past(state) == stc_pkg::ST_STOP_WAIT && $past(timer) >= stc_pkg::STOP_DELAY_TICKS)
    else $error("stop before delay");
  chk_locked_holds: assert property (locked && !panel_reset |=> locked)
    else $error("lock flag dropped");
  chk_par_order: assert property (state == stc_pkg::ST_RET_OPEN_LAST
    |-> $past(state) == stc_pkg::ST_RET_CLOSE_FIRST || $stable(state))
    else $error("backup opened before priority closed");
  chk_lock_manual: assert property (lock_in && state == stc_pkg::ST_IDLE
    |=> !(|open_order) && !(|close_order)) else $error("order passed under lock");
  chk_close_at_start: assert property (state == stc_pkg::ST_XFER_CLOSE && dst_gen
    && close_after_start && !sw[dst] && timer < stc_pkg::GEN_TIMEOUT_TICKS
    |=> close_order[dst]) else $error("generator close held back");
endmodule : stc_source_transfer_controller
`default_nettype wire

// [bench/stc_switchgear_model.sv]
/*
  Behavioural model of two motorised switches and a generating set.
  Assumes the orders come from the controller on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module stc_switchgear_model (
  input wire logic clock,
  input wire logic [1:0] open_order,
  input wire logic [1:0] close_order,
  input wire logic gen_start,
  input wire logic gen_ok,
  output logic [1:0] sw_closed,
  output logic gen_volt
);
  // A mechanism only moves once an order has stood for four cycles.
  int cnt [2];
  initial begin
    sw_closed = 2'h1;
    gen_volt = 1'b0;
    cnt[0] = 0;
    cnt[1] = 0;
  end
  always @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      cnt[i] <= (open_order[i] ^ close_order[i]) ? cnt[i] + 1 : 0;
      if (cnt[i] == 4) sw_closed[i] <= close_order[i];
    end
    // A failing set never shows voltage, so abandonment can be exercised.
    gen_volt <= gen_start & gen_ok;
  end
endmodule : stc_switchgear_model
`default_nettype wire

// [bench/stc_source_transfer_controller_test.sv]
/*
  Self-checking bench for the source transfer controller.
  Assumes the switchgear model closes the loop on switch positions.
*/
`timescale 1ns/1ps
`default_nettype none
module stc_source_transfer_controller_test;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] sw_closed, earth_closed, volt_present, fault_current, manual_open, manual_close;
  logic [1:0] open_order, close_order;
  logic gen_volt_input, transfer_lock, priority_select, parallel_confirm, gen_override;
  logic local_mode, auto_on, gen_variant, first_module, gen_channel, volt_from_relay;
  logic fault_lock_en, parallel_en, close_after_start, panel_reset, gen_ok;
  logic gen_start, gen_stop, locked, automation_active;
  logic [10:0] transfer_delay;
  logic [8:0] return_delay;
  stc_pkg::stc_mode_type mode;
  int errors = 0;
  int n_tests = 0;
  wire logic [6:0] obs = {locked, gen_stop, gen_start, close_order, open_order};

  stc_source_transfer_controller #(.TICK_CYCLES(10)) uut (
    .clock, .arst_n, .sw_closed, .earth_closed, .volt_present, .fault_current,
    .gen_volt_input, .transfer_lock, .priority_select, .parallel_confirm, .gen_override,
    .local_mode, .manual_open, .manual_close, .auto_on, .mode, .gen_variant, .first_module,
    .gen_channel, .volt_from_relay, .fault_lock_en, .parallel_en, .close_after_start,
    .transfer_delay, .return_delay, .panel_reset, .open_order, .close_order, .gen_start,
    .gen_stop, .locked, .automation_active
  );
  stc_switchgear_model model (
    .clock, .open_order, .close_order, .gen_start, .gen_ok, .sw_closed,
    .gen_volt(gen_volt_input)
  );

  initial begin
    forever #25 clock = ~clock;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask : step

  task automatic check(input logic [6:0] got, input logic [6:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : check

  // Bounded wait on one output bit, then compare it.
  task automatic await(input int b, input logic v, input int lim);
    int i;
    i = 0;
    while (obs[b] !== v && i < lim) begin
      step(1);
      i++;
    end
    check(7'(obs[b]), 7'(v));
  endtask : await

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  initial begin
    {earth_closed, fault_current, manual_open, manual_close} = 8'h00;
    {transfer_lock, priority_select, parallel_confirm, gen_override, local_mode} = 5'h00;
    {gen_variant, gen_channel, volt_from_relay, parallel_en, close_after_start} = 5'h00;
    {auto_on, first_module, fault_lock_en, panel_reset, gen_ok} = 5'h1C;
    volt_present = 2'h3;
    mode = stc_pkg::MODE_SEMI;
    transfer_delay = 11'h002;
    return_delay = 9'h000;
    step(8);
    arst_n = 1'b1;
    check(obs, 7'h00);
    // Each blocker alone must hold off a changeover on channel 0 voltage loss.
    for (int k = 0; k < 3; k++) begin
      {fault_current[1], earth_closed[0], transfer_lock} = 3'(1 << k);
      volt_present = 2'h2;
      step(150);
      check(7'(obs[1:0]), 7'h00);
    end
    {fault_current[1], earth_closed[0], transfer_lock} = 3'h0;
    step(12);
    check(7'(obs[1:0]), 7'h00);
    await(0, 1'b1, 300);
    check(7'(close_order), 7'h00);
    await(3, 1'b1, 100);
    await(3, 1'b0, 100);
    volt_present = 2'h3;
    step(200);
    check(obs, 7'h00);
    mode = stc_pkg::MODE_AUTO1;
    for (int p = 0; p < 2; p++) begin
      int f;
      f = 1 + p;
      {parallel_en, parallel_confirm} = {2{p[0]}};
      if (p == 1) begin
        volt_present = 2'h2;
        await(3, 1'b1, 300);
        await(3, 1'b0, 100);
        volt_present = 2'h3;
      end
      await(f, 1'b1, 300);
      check(7'(obs[3 - f]), 7'h00);
      await(3 - f, 1'b1, 100);
      step(20);
    end
    {parallel_en, parallel_confirm} = 2'h0;
    {gen_variant, gen_channel} = 2'h3;
    mode = stc_pkg::MODE_ONE_1TO2;
    volt_present = 2'h2;
    await(0, 1'b1, 300);
    check(7'(obs[4]), 7'h01);
    step(100);
    check(7'(obs[3]), 7'h00);
    await(6, 1'b1, 7000);
    check(7'(obs[4]), 7'h00);
    step(50);
    check(7'(obs[1:0]), 7'h00);
    panel_reset = 1'b1;
    step(2);
    panel_reset = 1'b0;
    step(1);
    check(7'(obs[6]), 7'h00);
    volt_present = 2'h3;
    local_mode = 1'b1;
    manual_close = 2'h1;
    await(2, 1'b1, 6);
    step(10);
    manual_close = 2'h0;
    local_mode = 1'b0;
    step(20);
    mode = stc_pkg::MODE_SEMI;
    close_after_start = 1'b1;
    volt_present = 2'h2;
    await(4, 1'b1, 300);
    await(3, 1'b1, 12);
    gen_ok = 1'b1;
    step(20);
    return_delay = 9'h001;
    volt_present = 2'h3;
    step(400);
    check(7'(obs[1]), 7'h00);
    await(1, 1'b1, 300);
    await(2, 1'b1, 100);
    await(2, 1'b0, 100);
    step(500);
    check(7'(obs[5]), 7'h00);
    await(5, 1'b1, 200);
    check(7'(obs[4]), 7'h00);
    close_out();
  end

  initial begin
    #2000000;
    errors++;
    close_out();
  end
endmodule : stc_source_transfer_controller_test
`default_nettype wire
